// ### shared/cws_pkg.sv
// package: register map, field layout and states of the shutdown and input-select control
package cws_pkg;
   // register byte offsets on the bus
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] MASK_OFFSET = 4'h8;
   localparam logic [3:0] STATE_OFFSET = 4'hC;
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 32;

   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;

   // shutdown level codes
   localparam logic [1:0] LEVEL_DRIVE_HIGH = 2'h3;
   localparam logic [1:0] LEVEL_DRIVE_LOW = 2'h2;
   localparam logic [1:0] LEVEL_FLOAT = 2'h1;
   localparam logic [1:0] LEVEL_INACTIVE = 2'h0;

   // input source codes
   localparam logic [1:0] SRC_PULSE_TWO = 2'h3;
   localparam logic [1:0] SRC_PULSE_ONE = 2'h2;
   localparam logic [1:0] SRC_COMP_TWO = 2'h1;
   localparam logic [1:0] SRC_COMP_ONE = 2'h0;

   // status and mask bit positions
   localparam int EVT_SHUTDOWN_BIT = 0;
   localparam int EVT_RESUME_BIT = 1;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] outBShutdownLevel;
      logic [1:0] outAShutdownLevel;
      logic [1:0] reserved;
      logic [1:0] inputSourceSel;
   } cws_ctrl_t;

   // one output pin: level and enable
   typedef struct packed {
      logic oe;
      logic value;
   } cws_pin_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SHUT = 2'b01,
      ST_HOLD = 2'b10
   } cws_state_t;
endpackage : cws_pkg

// ### logic/cws_shutdown_ctl.sv
// module: shutdown output overrides, input source select and register slave
// Operation
// - shutdown B field 11/10 forces B high/low
// - shutdown B field 01 floats B pin
// - shutdown B field 00: inactive after dead-band
// - shutdown A field 11/10 forces A high/low
// - shutdown A field 01 floats A pin
// - shutdown A field 00: inactive after dead-band
// - overrides apply while shutdown flag set and in hold after it clears
// - middle two control bits read zero
// - codes 01/00 pick comparator two/one
// - overrides hold until first input rising edge
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module cws_shutdown_ctl (
   input wire logic clock,
   input wire logic rstn,
   // wishbone classic slave
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbWeI,
   input wire logic [cws_pkg::ADDR_WIDTH-1:0] wbAdrI,
   input wire logic [3:0] wbSelI,
   input wire logic [cws_pkg::DATA_WIDTH-1:0] wbDatI,
   output logic [cws_pkg::DATA_WIDTH-1:0] wbDatO,
   output logic wbAckO,
   // sources
   input wire logic comparatorOneOut,
   input wire logic comparatorTwoOut,
   input wire logic pulseModOneOut,
   input wire logic pulseModTwoOut,
   // from neighbouring generator blocks
   input wire logic shutdownEventFlag,
   input wire logic outAInvert,
   input wire logic outBInvert,
   input wire logic deadBandDoneA,
   input wire logic deadBandDoneB,
   // output pins
   output logic waveOutFirst,
   output logic waveOutFirstOe,
   output logic waveOutSecond,
   output logic waveOutSecondOe,
   output logic irq
);

   cws_pkg::cws_ctrl_t ctrl_reg;
   logic [1:0] status_reg;
   logic [1:0] mask_reg;
   cws_pkg::cws_state_t state_reg;
   cws_pkg::cws_state_t state_next;
   logic prevIn_reg;
   logic selIn;
   logic risingIn;
   logic busReq;
   logic busWrite;
   logic [1:0] eventSet;
   cws_pkg::cws_pin_t pinA;
   cws_pkg::cws_pin_t pinB;

   // pin drive during override or normal run
   function automatic cws_pkg::cws_pin_t pinDrive(
      input logic [1:0] level,
      input logic override,
      input logic invert,
      input logic normal,
      input logic dbDone
   );
      cws_pkg::cws_pin_t p;
      p.oe = 1'b1;
      p.value = normal;
      if (override) begin
         case (level)
            cws_pkg::LEVEL_DRIVE_HIGH: p.value = 1'b1;
            cws_pkg::LEVEL_DRIVE_LOW: p.value = 1'b0;
            cws_pkg::LEVEL_FLOAT: begin
               p.oe = 1'b0;
               p.value = 1'b0;
            end
            default: begin
               if (dbDone) begin
                  p.value = invert;
               end
            end
         endcase
      end
      return p;
   endfunction : pinDrive

   // input source routing
   always_comb begin
      case (ctrl_reg.inputSourceSel)
         cws_pkg::SRC_PULSE_TWO: selIn = pulseModTwoOut;
         cws_pkg::SRC_PULSE_ONE: selIn = pulseModOneOut;
         cws_pkg::SRC_COMP_TWO: selIn = comparatorTwoOut;
         default: selIn = comparatorOneOut;
      endcase
   end

   assign risingIn = selIn & ~prevIn_reg;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prevIn_reg <= 1'b0;
      end else begin
         prevIn_reg <= selIn;
      end
   end

   // override state
   always_comb begin
      case (state_reg)
         cws_pkg::ST_RUN: begin
            state_next = shutdownEventFlag ? cws_pkg::ST_SHUT : cws_pkg::ST_RUN;
         end
         cws_pkg::ST_SHUT, cws_pkg::ST_HOLD: begin
            if (shutdownEventFlag) begin
               state_next = cws_pkg::ST_SHUT;
            end else if (risingIn) begin
               state_next = cws_pkg::ST_RUN;
            end else begin
               state_next = cws_pkg::ST_HOLD;
            end
         end
         default: state_next = cws_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= cws_pkg::ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // pin outputs in normal run: selected input on A, its complement on B, each XOR'd with its invert input
   always_comb begin
      pinA = pinDrive(ctrl_reg.outAShutdownLevel, state_reg != cws_pkg::ST_RUN,
                      outAInvert, selIn ^ outAInvert, deadBandDoneA);
      pinB = pinDrive(ctrl_reg.outBShutdownLevel, state_reg != cws_pkg::ST_RUN,
                      outBInvert, ~selIn ^ outBInvert, deadBandDoneB);
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         waveOutFirst <= 1'b0;
         waveOutFirstOe <= 1'b0;
         waveOutSecond <= 1'b0;
         waveOutSecondOe <= 1'b0;
      end else begin
         waveOutFirst <= pinA.value;
         waveOutFirstOe <= pinA.oe;
         waveOutSecond <= pinB.value;
         waveOutSecondOe <= pinB.oe;
      end
   end

   // bus slave
   assign busReq = wbCycI & wbStbI & ~wbAckO;
   assign busWrite = busReq & wbWeI & wbSelI[0];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wbAckO <= 1'b0;
      end else begin
         wbAckO <= busReq;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= cws_pkg::CTRL_RESET;
      end else if (busWrite && wbAdrI == cws_pkg::CTRL_OFFSET) begin
         ctrl_reg.outBShutdownLevel <= wbDatI[7:6];
         ctrl_reg.outAShutdownLevel <= wbDatI[5:4];
         ctrl_reg.inputSourceSel <= wbDatI[1:0];
         ctrl_reg.reserved <= 2'h0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mask_reg <= cws_pkg::MASK_RESET;
      end else if (busWrite && wbAdrI == cws_pkg::MASK_OFFSET) begin
         mask_reg <= wbDatI[1:0];
      end
   end

   // sticky events: shutdown entered, normal run resumed; set wins over clear
   assign eventSet[cws_pkg::EVT_SHUTDOWN_BIT] = (state_reg != cws_pkg::ST_SHUT) &&
                                               (state_next == cws_pkg::ST_SHUT);
   assign eventSet[cws_pkg::EVT_RESUME_BIT] = (state_reg != cws_pkg::ST_RUN) &&
                                             (state_next == cws_pkg::ST_RUN);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         status_reg <= cws_pkg::STATUS_RESET;
      end else if (busWrite && wbAdrI == cws_pkg::STATUS_OFFSET) begin
         status_reg <= (status_reg & ~wbDatI[1:0]) | eventSet;
      end else begin
         status_reg <= status_reg | eventSet;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_reg & mask_reg);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wbDatO <= '0;
      end else if (busReq && !wbWeI) begin
         case (wbAdrI)
            cws_pkg::CTRL_OFFSET: wbDatO <= {24'h000000, ctrl_reg};
            cws_pkg::STATUS_OFFSET: wbDatO <= {30'h0, status_reg};
            cws_pkg::MASK_OFFSET: wbDatO <= {30'h0, mask_reg};
            cws_pkg::STATE_OFFSET: wbDatO <= {28'h0000000, selIn, shutdownEventFlag, state_reg};
            default: wbDatO <= '0;
         endcase
      end else begin
         wbDatO <= '0;
      end
   end

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   wire logic overrideOn = state_reg != cws_pkg::ST_RUN;

   a_b_force_level: assert property (
      (overrideOn && ctrl_reg.outBShutdownLevel[1])
      |=> (waveOutSecondOe && waveOutSecond == $past(ctrl_reg.outBShutdownLevel[0])))
      else $error("B override level wrong");

   a_b_float: assert property (
      (overrideOn && ctrl_reg.outBShutdownLevel == cws_pkg::LEVEL_FLOAT) |=> !waveOutSecondOe)
      else $error("B pin not floated");

   a_b_inactive: assert property (
      (overrideOn && ctrl_reg.outBShutdownLevel == cws_pkg::LEVEL_INACTIVE && deadBandDoneB)
      |=> (waveOutSecondOe && waveOutSecond == $past(outBInvert)))
      else $error("B inactive level wrong");

   a_a_force_level: assert property (
      (overrideOn && ctrl_reg.outAShutdownLevel[1])
      |=> (waveOutFirstOe && waveOutFirst == $past(ctrl_reg.outAShutdownLevel[0])))
      else $error("A override level wrong");

   a_a_float: assert property (
      (overrideOn && ctrl_reg.outAShutdownLevel == cws_pkg::LEVEL_FLOAT) |=> !waveOutFirstOe)
      else $error("A pin not floated");

   a_a_inactive: assert property (
      (overrideOn && ctrl_reg.outAShutdownLevel == cws_pkg::LEVEL_INACTIVE && deadBandDoneA)
      |=> (waveOutFirstOe && waveOutFirst == $past(outAInvert)))
      else $error("A inactive level wrong");

   a_run_normal: assert property (
      (state_reg == cws_pkg::ST_RUN)
      |=> (waveOutFirstOe && waveOutSecondOe && waveOutFirst == $past(selIn ^ outAInvert)
           && waveOutSecond == $past(~selIn ^ outBInvert)))
      else $error("normal output wrong");

   a_flag_enters: assert property (
      shutdownEventFlag |=> state_reg == cws_pkg::ST_SHUT)
      else $error("shutdown not entered");

   a_rsv_zero: assert property (
      (busReq && !wbWeI && wbAdrI == cws_pkg::CTRL_OFFSET) |=> wbDatO[3:2] == 2'h0)
      else $error("reserved bits not zero");

   a_src_route: assert property (
      (ctrl_reg.inputSourceSel == cws_pkg::SRC_PULSE_TWO) |-> selIn == pulseModTwoOut)
      else $error("source route wrong");

   a_comp_route: assert property (
      (ctrl_reg.inputSourceSel == cws_pkg::SRC_COMP_TWO) |-> selIn == comparatorTwoOut)
      else $error("comparator route wrong");

   sequence holdWaiting;
      (state_reg != cws_pkg::ST_RUN) && !shutdownEventFlag && !risingIn;
   endsequence

   sequence holdReleased;
      (state_reg != cws_pkg::ST_RUN) && !shutdownEventFlag && risingIn;
   endsequence

   a_hold_persist: assert property (
      holdWaiting |=> state_reg == cws_pkg::ST_HOLD)
      else $error("override dropped early");

   a_hold_release: assert property (
      holdReleased |=> state_reg == cws_pkg::ST_RUN ##1 waveOutFirstOe)
      else $error("override not released");

   a_irq_level: assert property (
      (|(status_reg & mask_reg)) |=> irq)
      else $error("irq not raised");

   a_irq_low: assert property (
      !(|(status_reg & mask_reg)) |=> !irq)
      else $error("irq not lowered");

   a_pulse_one_route: assert property (
      (ctrl_reg.inputSourceSel == cws_pkg::SRC_PULSE_ONE) |-> selIn == pulseModOneOut)
      else $error("pulse one route wrong");

   a_comp_one_route: assert property (
      (ctrl_reg.inputSourceSel == cws_pkg::SRC_COMP_ONE) |-> selIn == comparatorOneOut)
      else $error("comparator one route wrong");

   a_shut_event: assert property (
      (state_reg == cws_pkg::ST_RUN && shutdownEventFlag)
      |=> status_reg[cws_pkg::EVT_SHUTDOWN_BIT])
      else $error("shutdown event not recorded");

   a_resume_event: assert property (
      holdReleased |=> status_reg[cws_pkg::EVT_RESUME_BIT])
      else $error("resume event not recorded");

   a_status_clear: assert property (
      (busWrite && wbAdrI == cws_pkg::STATUS_OFFSET && wbDatI[cws_pkg::EVT_SHUTDOWN_BIT]
       && !eventSet[cws_pkg::EVT_SHUTDOWN_BIT]) |=> !status_reg[cws_pkg::EVT_SHUTDOWN_BIT])
      else $error("status bit not cleared");

   a_ack_answer: assert property (
      busReq |=> wbAckO)
      else $error("bus request not acked");

   a_ack_pulse: assert property (
      wbAckO |=> !wbAckO)
      else $error("ack held too long");

   a_read_idle: assert property (
      !wbAckO |-> wbDatO == '0)
      else $error("read data outside ack");

endmodule : cws_shutdown_ctl
`default_nettype wire

// ### testbench/cws_pin_load.sv
// partner: switch driver inputs that watch the two output pins
`timescale 1ns/1ns
`default_nettype none
module cws_pin_load (
   input wire logic clock,
   input wire logic rstn,
   input wire logic value,
   input wire logic oe,
   output logic pad
);
   logic last_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         last_reg <= 1'h0;
      end else if (oe) begin
         last_reg <= value;
      end
   end
   // a floated pin shows the inverse of the last driven level
   assign pad = oe ? value : ~last_reg;
endmodule : cws_pin_load
`default_nettype wire

// ### testbench/cws_shutdown_ctl_test.sv
// testbench: register, source select and shutdown override checks
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errTotal++; \
 $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module cws_shutdown_ctl_test;
   logic clock = 1'h0, rstn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, flag = 1'h0;
   logic invA = 1'h1, invB = 1'h0, dbA = 1'h0, dbB = 1'h0;
   logic [3:0] adr = 4'h0, src = 4'h0;
   logic [31:0] datI = 32'h0, rd, datO;
   logic ack, pinA, oeA, pinB, oeB, irq, padA, padB;
   int errTotal = 0, checked = 0;
   always #5 clock = ~clock;
   cws_shutdown_ctl DUT (.clock(clock), .rstn(rstn), .wbCycI(cyc), .wbStbI(stb),
      .wbWeI(we), .wbAdrI(adr), .wbSelI(4'hF), .wbDatI(datI), .wbDatO(datO), .wbAckO(ack),
      .comparatorOneOut(src[0]), .comparatorTwoOut(src[1]), .pulseModOneOut(src[2]),
      .pulseModTwoOut(src[3]), .shutdownEventFlag(flag), .outAInvert(invA),
      .outBInvert(invB), .deadBandDoneA(dbA), .deadBandDoneB(dbB), .waveOutFirst(pinA),
      .waveOutFirstOe(oeA), .waveOutSecond(pinB), .waveOutSecondOe(oeB), .irq(irq));
   cws_pin_load loadA (.clock(clock), .rstn(rstn), .value(pinA), .oe(oeA), .pad(padA));
   cws_pin_load loadB (.clock(clock), .rstn(rstn), .value(pinB), .oe(oeB), .pad(padB));
   task automatic wbCycle(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      datI <= d;
      do @(posedge clock); while (ack !== 1'h1 && ++n < 50);
      rd = datO;
      if (n >= 50) errTotal++;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask : wbCycle
   task automatic settle;
      repeat (3) @(posedge clock);
   endtask : settle
   task automatic testDone;
      $display("checks %0d mismatches %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : testDone
   initial begin
      #200000;
      errTotal++;
      testDone;
   end
   initial begin
      repeat (6) @(posedge clock);
      rstn <= 1'h1;
      wbCycle(1'h0, cws_pkg::CTRL_OFFSET, 32'h0);
      `CHK(rd, 32'h00000000)
      wbCycle(1'h1, cws_pkg::CTRL_OFFSET, 32'hFFFFFFFF);
      wbCycle(1'h0, cws_pkg::CTRL_OFFSET, 32'h0);
      `CHK(rd, 32'h000000F3)
      wbCycle(1'h0, 4'h2, 32'h0);
      `CHK(rd, 32'h00000000)
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         wbCycle(1'h1, cws_pkg::CTRL_OFFSET, 32'(c));
         for (int v = 0; v < 2; v++) begin
            src <= v[0] ? (4'h1 << c) : ~(4'h1 << c);
            settle;
            `CHK({oeA, padA, oeB, padB}, {1'h1, v[0] ^ invA, 1'h1, ~v[0] ^ invB})
         end
      end
      $display("test source select done");
      wbCycle(1'h1, cws_pkg::MASK_OFFSET, 32'h1);
      wbCycle(1'h1, cws_pkg::STATUS_OFFSET, 32'h3);
      invB <= 1'h1;
      flag <= 1'h1;
      for (int l = 1; l < 4; l++) begin
         wbCycle(1'h1, cws_pkg::CTRL_OFFSET, 32'(l * 8'h50));
         settle;
         if (l == 1) `CHK({oeA, oeB}, 2'h0)
         else `CHK({oeA, padA, oeB, padB}, {1'h1, l[0], 1'h1, l[0]})
      end
      `CHK(irq, 1'h1)
      wbCycle(1'h1, cws_pkg::CTRL_OFFSET, 32'h0);
      src <= 4'h1;
      settle;
      `CHK({padA, padB}, {~invA, invB})
      dbA <= 1'h1;
      dbB <= 1'h1;
      settle;
      `CHK({oeA, padA, oeB, padB}, {1'h1, invA, 1'h1, invB})
      $display("test shutdown levels done");
      flag <= 1'h0;
      settle;
      `CHK({padA, padB}, {invA, invB})
      src <= 4'h0;
      settle;
      `CHK({padA, padB}, {invA, invB})
      src <= 4'h1;
      settle;
      `CHK({padA, padB}, {~invA, invB})
      wbCycle(1'h0, cws_pkg::STATUS_OFFSET, 32'h0);
      `CHK(rd, 32'h00000003)
      wbCycle(1'h0, cws_pkg::STATE_OFFSET, 32'h0);
      `CHK(rd, 32'h00000008)
      wbCycle(1'h1, cws_pkg::STATUS_OFFSET, 32'h1);
      settle;
      `CHK(irq, 1'h0)
      $display("test release and interrupt done");
      rstn <= 1'h0;
      @(posedge clock);
      `CHK({oeA, oeB, irq, ack}, 4'h0)
      rstn <= 1'h1;
      wbCycle(1'h0, cws_pkg::CTRL_OFFSET, 32'h0);
      `CHK(rd, 32'h00000000)
      $display("test mid-run reset done");
      testDone;
   end
endmodule : cws_shutdown_ctl_test
`default_nettype wire
